// File: rtl/slc_pkg.sv
/*
 * Shared constants and types for the sleep mode controller: mode codes,
 * register selects, reset values, limits and time bases.
 * Assumes a single 20 MHz module clock feeding every file that imports it.
 */
package slc_pkg;

   // Time base
   localparam int CLK_PERIOD_NS  = 50;
   localparam int SLEEP_UNIT_NS  = 10_000_000;              // Sleep period unit, 10 ms
   localparam int WAKE_UNIT_NS   = 1_000_000;               // Wake duration unit, 1 ms
   localparam int SLEEP_UNIT_CYC = SLEEP_UNIT_NS / CLK_PERIOD_NS;
   localparam int WAKE_UNIT_CYC  = WAKE_UNIT_NS / CLK_PERIOD_NS;
   localparam logic [23:0] CHECK_MS = 24'h000001;           // Brief activity check window

   // Sleep mode codes
   localparam logic [7:0] MODE_NORMAL    = 8'h00;
   localparam logic [7:0] MODE_PIN       = 8'h01;
   localparam logic [7:0] MODE_ASYNC     = 8'h04;
   localparam logic [7:0] MODE_ASYNC_PIN = 8'h05;
   localparam logic [7:0] MODE_SUPPORT   = 8'h07;
   localparam logic [7:0] MODE_SYNC      = 8'h08;

   // Register selects on the configuration port
   localparam logic [2:0] SEL_MODE   = 3'h0;
   localparam logic [2:0] SEL_OPT    = 3'h1;
   localparam logic [2:0] SEL_DIV    = 3'h2;
   localparam logic [2:0] SEL_SP     = 3'h3;
   localparam logic [2:0] SEL_ST     = 3'h4;
   localparam logic [2:0] SEL_STATUS = 3'h5;

   // Reset values and limits
   localparam logic [7:0]  RST_MODE = 8'h00;
   localparam logic [15:0] RST_OPT  = 16'h0002;
   localparam logic [15:0] RST_DIV  = 16'h0001;
   localparam logic [23:0] RST_SP   = 24'h00012C;
   localparam logic [23:0] RST_ST   = 24'h000D08;
   localparam logic [15:0] MAX_OPT  = 16'h013E;
   localparam logic [23:0] MAX_SP   = 24'h15F900;
   localparam logic [23:0] MAX_ST   = 24'h36EE80;
   localparam logic [7:0]  RATE_SLOWEST = 8'h00;

   // Option bit positions
   localparam int OPT_B0       = 0;
   localparam int OPT_B1       = 1;
   localparam int OPT_FULL_ST  = 8;
   localparam int OPT_RAND_IO  = 10;

   typedef struct packed {
      logic [7:0]  mode;
      logic [15:0] opt;
      logic [15:0] div;
      logic [23:0] sp;
      logic [23:0] st;
   } slc_cfg_t;

   typedef enum logic [3:0] {
      ST_AWAKE = 4'b0001,
      ST_SLEEP = 4'b0010,
      ST_CHECK = 4'b0100,
      ST_WAKE  = 4'b1000
   } slc_state_t;

endpackage : slc_pkg

// File: rtl/slc_tick_timer.sv
/*
 * Prescaled interval timer: divides the module clock down to a unit tick
 * and counts ticks since the last restart, flagging when a target is met.
 * Assumes restart_i comes from logic on the same clock.
 */
`timescale 1ns/1ps
module slc_tick_timer #(
   parameter int PRESCALE = 20000,
   parameter int W        = 24
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         restart_i,
   input  wire logic [W-1:0] target_i,
   output logic      [W-1:0] elapsed_o,
   output logic              done_o
);
   localparam int PW = $clog2(PRESCALE + 1);
   localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE - 1);

   logic [PW-1:0] pre_r;
   logic [PW-1:0] pre_nxt;
   logic [W-1:0]  el_nxt;
   logic          done_nxt;

   // Restart clears both stages so a new interval is always whole
   always_comb begin
      pre_nxt = pre_r;
      el_nxt  = elapsed_o;
      if (restart_i) begin
         pre_nxt = '0;
         el_nxt  = '0;
      end else if (pre_r == PRE_LAST) begin
         pre_nxt = '0;
         if (elapsed_o != '1) begin                 // Saturate, never wrap
            el_nxt = elapsed_o + W'(1);
         end
      end else begin
         pre_nxt = pre_r + PW'(1);
      end
      done_nxt = !restart_i && (el_nxt >= target_i);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre_r     <= '0;
         elapsed_o <= '0;
         done_o    <= 1'b0;
      end else begin
         pre_r     <= pre_nxt;
         elapsed_o <= el_nxt;
         done_o    <= done_nxt;
      end
   end

   a_done_elapsed: assert property (@(posedge clk_i) disable iff (rst_i)
      done_o |-> (elapsed_o >= $past(target_i)))
      else $error("timer done before target reached");

endmodule : slc_tick_timer

// File: rtl/slc_sleep_ctrl.sv
/*
 * Sleep and wake controller: mode register file on a simple select port,
 * sleep/wake state machine, awake divider and I/O sample timing.
 * Assumes one 20 MHz clock; host sleep request is an asynchronous pin,
 * activity and sync strobes come from logic on the same clock.
 */
`timescale 1ns/1ps
// Overview of operation
// - Mode 0: always awake, request ignored
// - Mode 1: sleep follows host request pin
// - Mode 4: cycle sleep period and wake
// - Mode 5: cyclic while requested, wake on release
// - Mode 7: permanently awake, sync capable
// - Mode 8: sleep period then wake duration
// - Sync modes refused at slowest rate
// - Options reject bits 0+1 or above max
// - Option 8: always stay full wake
// - Option 10: randomise sample within wake
// - Indicator once per N sleep periods
// - Silent wake checks data, else sleeps
// - Divider 1: indicator after every period
// - Divider ignored in synchronous modes
// - Sleep period in 10 ms units
// - Sleep period 0 means no sleep
// - Sync wake lasts wake duration, 1 ms
// - Async wake extends after data
module slc_sleep_ctrl
   import slc_pkg::*;
#(
   parameter int SLEEP_TICK_CYC = SLEEP_UNIT_CYC,
   parameter int WAKE_TICK_CYC  = WAKE_UNIT_CYC
) (
   input  wire logic        SYS_CLK_I,
   input  wire logic        RESET_I,
   input  wire logic        HOST_SLEEP_REQUEST_I,
   input  wire logic        ACTIVITY_I,
   input  wire logic        NET_SYNC_I,
   input  wire logic [7:0]  RADIO_RATE_SETTING_I,
   input  wire logic        CFG_WR_I,
   input  wire logic [2:0]  CFG_SEL_I,
   input  wire logic [23:0] CFG_WDATA_I,
   output logic      [23:0] CFG_RDATA_O,
   output logic             CFG_ERR_O,
   output logic             AWAKE_O,
   output logic             SLEEP_O,
   output logic             PULSE_OUTPUT_PIN_O,
   output logic             SAMPLE_O
);
   slc_cfg_t   cfg_r, cfg_nxt;
   slc_state_t state_r, state_nxt;
   logic        req_s1_r, req_s2_r;
   logic        err_nxt;
   logic [23:0] rdata_nxt;
   logic [15:0] cyc_cnt_r, cyc_cnt_nxt;
   logic        seen_r, seen_nxt;
   logic [15:0] lfsr_r, lfsr_nxt;
   logic [23:0] samp_at_r, samp_at_nxt;
   logic        samp_done_r, samp_done_nxt;
   logic        awake_nxt, sleep_nxt, pulse_nxt, sample_nxt;
   logic        sleep_restart, wake_restart;
   logic        sleep_done, wake_done;
   logic [23:0] wake_el;
   logic        is_sync, is_async, new_sync, new_async, mode_ok;
   logic        pin_sleep, cyc_ok;

   // Host pin crosses into the clock domain through two flops
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         req_s1_r <= 1'b0;
         req_s2_r <= 1'b0;
      end else begin
         req_s1_r <= HOST_SLEEP_REQUEST_I;
         req_s2_r <= req_s1_r;
      end
   end

   // Mode class decode
   always_comb begin
      is_sync   = (cfg_r.mode == MODE_SUPPORT) || (cfg_r.mode == MODE_SYNC);
      is_async  = (cfg_r.mode == MODE_ASYNC) || (cfg_r.mode == MODE_ASYNC_PIN);
      new_sync  = (CFG_WDATA_I[7:0] == MODE_SUPPORT) || (CFG_WDATA_I[7:0] == MODE_SYNC);
      new_async = (CFG_WDATA_I[7:0] == MODE_ASYNC) || (CFG_WDATA_I[7:0] == MODE_ASYNC_PIN);
      mode_ok   = (CFG_WDATA_I[23:8] == '0) &&
                  ((CFG_WDATA_I[7:0] == MODE_NORMAL) || (CFG_WDATA_I[7:0] == MODE_PIN) || new_async || new_sync);
      // Sync modes unusable at slowest rate and never entered straight from async
      if (new_sync && ((RADIO_RATE_SETTING_I == RATE_SLOWEST) || is_async)) begin
         mode_ok = 1'b0;
      end
      if (new_async && is_sync) begin
         mode_ok = 1'b0;
      end
      pin_sleep = (cfg_r.mode == MODE_PIN) && req_s2_r;
      // Cyclic sleep allowed; period 0 means stay awake in async modes
      cyc_ok    = ((cfg_r.mode == MODE_ASYNC) ||
                   ((cfg_r.mode == MODE_ASYNC_PIN) && req_s2_r)) && (cfg_r.sp != '0);
      cyc_ok    = cyc_ok || (cfg_r.mode == MODE_SYNC);
   end

   // Register writes are checked; a refused write leaves the value intact
   always_comb begin
      cfg_nxt   = cfg_r;
      err_nxt   = 1'b0;
      rdata_nxt = '0;
      if (CFG_WR_I) begin
         unique case (CFG_SEL_I)
            SEL_MODE: begin
               if (mode_ok) cfg_nxt.mode = CFG_WDATA_I[7:0];
               else err_nxt = 1'b1;
            end
            SEL_OPT: begin
               if ((CFG_WDATA_I[OPT_B0] && CFG_WDATA_I[OPT_B1]) ||
                   (CFG_WDATA_I > {8'h00, MAX_OPT})) err_nxt = 1'b1;
               else cfg_nxt.opt = CFG_WDATA_I[15:0];
            end
            SEL_DIV: begin
               if ((CFG_WDATA_I[15:0] == '0) || (CFG_WDATA_I[23:16] != '0)) err_nxt = 1'b1;
               else cfg_nxt.div = CFG_WDATA_I[15:0];
            end
            SEL_SP: begin
               if (CFG_WDATA_I > MAX_SP) err_nxt = 1'b1;
               else cfg_nxt.sp = CFG_WDATA_I;
            end
            SEL_ST: begin
               if ((CFG_WDATA_I == '0) || (CFG_WDATA_I > MAX_ST)) err_nxt = 1'b1;
               else cfg_nxt.st = CFG_WDATA_I;
            end
            default: err_nxt = 1'b1;                                              // Status is read-only
         endcase
      end
      unique case (CFG_SEL_I)
         SEL_MODE:   rdata_nxt = {16'h0000, cfg_r.mode};
         SEL_OPT:    rdata_nxt = {8'h00, cfg_r.opt};
         SEL_DIV:    rdata_nxt = {8'h00, cfg_r.div};
         SEL_SP:     rdata_nxt = cfg_r.sp;
         SEL_ST:     rdata_nxt = cfg_r.st;
         SEL_STATUS: rdata_nxt = {4'h0, cyc_cnt_r, state_r};
         default:    rdata_nxt = '0;
      endcase
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         cfg_r       <= '{mode: RST_MODE, opt: RST_OPT, div: RST_DIV, sp: RST_SP, st: RST_ST};
         CFG_ERR_O   <= 1'b0;
         CFG_RDATA_O <= '0;
      end else begin
         cfg_r       <= cfg_nxt;
         CFG_ERR_O   <= err_nxt;
         CFG_RDATA_O <= rdata_nxt;
      end
   end

   // Sleep/wake state machine
   always_comb begin
      state_nxt    = state_r;
      cyc_cnt_nxt  = cyc_cnt_r;
      seen_nxt     = seen_r || ACTIVITY_I;
      wake_restart = 1'b0;
      unique case (state_r)
         ST_AWAKE: begin
            if (pin_sleep) state_nxt = ST_SLEEP;
            else if (cyc_ok && cfg_r.mode == MODE_SYNC) state_nxt = ST_WAKE;
            else if (cyc_ok) state_nxt = ST_SLEEP;
         end
         ST_SLEEP: begin
            if (!(pin_sleep || cyc_ok)) begin
               state_nxt = ST_AWAKE;
            end else if (cyc_ok && (sleep_done || cfg_r.sp == '0)) begin
               if (is_sync) begin
                  state_nxt = ST_WAKE;
               end else if (cyc_cnt_r + 16'h0001 >= cfg_r.div) begin
                  state_nxt   = ST_WAKE;
                  cyc_cnt_nxt = '0;
               end else begin
                  state_nxt   = ST_CHECK;
                  cyc_cnt_nxt = cyc_cnt_r + 16'h0001;
               end
            end
         end
         ST_CHECK: begin
            if (!cyc_ok) state_nxt = pin_sleep ? ST_SLEEP : ST_AWAKE;
            else if (ACTIVITY_I) state_nxt = ST_WAKE;
            else if (wake_el >= CHECK_MS) state_nxt = ST_SLEEP;
         end
         ST_WAKE: begin
            if (!cyc_ok) begin
               state_nxt = pin_sleep ? ST_SLEEP : ST_AWAKE;
            end else if (is_sync && NET_SYNC_I) begin
               wake_restart = 1'b1;                                               // keep in step
            end else if (wake_done) begin
               if (cfg_r.sp == '0) wake_restart = 1'b1;                           // pulse again
               else state_nxt = ST_SLEEP;
            end else if (!is_sync && ACTIVITY_I) begin
               wake_restart = 1'b1;
            end else if (!is_sync && !cfg_r.opt[OPT_FULL_ST] && !seen_r && wake_el >= CHECK_MS) begin
               state_nxt = ST_SLEEP;                                              // early return
            end
         end
         default: state_nxt = ST_AWAKE;
      endcase
      // Both time bases restart on every state change
      sleep_restart = (state_nxt != state_r);
      wake_restart  = wake_restart || (state_nxt != state_r);
      if (state_nxt != state_r) seen_nxt = 1'b0;
      awake_nxt = (state_nxt == ST_AWAKE) || (state_nxt == ST_WAKE);
      sleep_nxt = (state_nxt == ST_SLEEP);
      pulse_nxt = is_sync && (cfg_r.sp == '0) && (state_nxt == ST_WAKE) && wake_restart;
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         state_r            <= ST_AWAKE;
         cyc_cnt_r          <= '0;
         seen_r             <= 1'b0;
         AWAKE_O            <= 1'b1;
         SLEEP_O            <= 1'b0;
         PULSE_OUTPUT_PIN_O <= 1'b0;
      end else begin
         state_r            <= state_nxt;
         cyc_cnt_r          <= cyc_cnt_nxt;
         seen_r             <= seen_nxt;
         AWAKE_O            <= awake_nxt;
         SLEEP_O            <= sleep_nxt;
         PULSE_OUTPUT_PIN_O <= pulse_nxt;
      end
   end

   // One I/O sample per sync wake, at a pseudo-random ms offset if enabled
   always_comb begin
      lfsr_nxt      = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      samp_at_nxt   = samp_at_r;
      samp_done_nxt = samp_done_r;
      sample_nxt    = 1'b0;
      if (wake_restart) begin
         samp_done_nxt = 1'b0;
         samp_at_nxt   = '0;
         if (cfg_r.opt[OPT_RAND_IO]) begin
            samp_at_nxt = {16'h0000, lfsr_r[7:0]} % cfg_r.st;
         end
      end else if (state_r == ST_WAKE && is_sync && !samp_done_r && wake_el >= samp_at_r) begin
         sample_nxt    = 1'b1;
         samp_done_nxt = 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         lfsr_r      <= 16'hACE1;
         samp_at_r   <= '0;
         samp_done_r <= 1'b1;
         SAMPLE_O    <= 1'b0;
      end else begin
         lfsr_r      <= lfsr_nxt;
         samp_at_r   <= samp_at_nxt;
         samp_done_r <= samp_done_nxt;
         SAMPLE_O    <= sample_nxt;
      end
   end

   // Sleep period in 10 ms ticks, wake duration in 1 ms ticks
   slc_tick_timer #(.PRESCALE(SLEEP_TICK_CYC), .W(24)) u_sleep_tmr (
      .clk_i     (SYS_CLK_I),
      .rst_i     (RESET_I),
      .restart_i (sleep_restart),
      .target_i  (cfg_r.sp),
      .elapsed_o (),
      .done_o    (sleep_done)
   );

   slc_tick_timer #(.PRESCALE(WAKE_TICK_CYC), .W(24)) u_wake_tmr (
      .clk_i     (SYS_CLK_I),
      .rst_i     (RESET_I),
      .restart_i (wake_restart),
      .target_i  (cfg_r.st),
      .elapsed_o (wake_el),
      .done_o    (wake_done)
   );

   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (RESET_I);

   sequence s_sleep_end;
      state_r == ST_SLEEP && sleep_done && cyc_ok;
   endsequence

   a_normal_awake: assert property (cfg_r.mode == MODE_NORMAL |=> AWAKE_O && !SLEEP_O)
      else $error("mode 0 not awake");
   a_pin_sleep: assert property (cfg_r.mode == MODE_PIN && req_s2_r |=> SLEEP_O)
      else $error("pin request did not sleep");
   a_pinwake_release: assert property (cfg_r.mode == MODE_ASYNC_PIN && !req_s2_r |=> AWAKE_O)
      else $error("released request did not wake");
   a_support_awake: assert property (cfg_r.mode == MODE_SUPPORT |=> AWAKE_O)
      else $error("support mode slept");
   a_sync_wake: assert property (s_sleep_end ##0 is_sync |=> state_r == ST_WAKE ##0 AWAKE_O)
      else $error("sync sleep did not end in wake");
   a_div_one: assert property (s_sleep_end ##0 cfg_r.div == 16'h0001 |=> AWAKE_O)
      else $error("divider 1 missed indicator");
   a_check_low: assert property (state_r == ST_CHECK |-> !AWAKE_O && !SLEEP_O)
      else $error("indicator high in check");
   a_sync_refused: assert property (CFG_WR_I && CFG_SEL_I == SEL_MODE && new_sync &&
      RADIO_RATE_SETTING_I == RATE_SLOWEST |=> CFG_ERR_O && $stable(cfg_r.mode))
      else $error("sync mode accepted at slowest rate");
   a_opt_reject: assert property (CFG_WR_I && CFG_SEL_I == SEL_OPT && CFG_WDATA_I[OPT_B0] &&
      CFG_WDATA_I[OPT_B1] |=> CFG_ERR_O ##0 cfg_r.opt == $past(cfg_r.opt))
      else $error("option bits 0 and 1 accepted");
   a_sp_zero: assert property (cfg_r.mode == MODE_ASYNC && cfg_r.sp == '0 |=> !SLEEP_O)
      else $error("slept with zero period");

endmodule : slc_sleep_ctrl

// File: sim/slc_host_model.sv
/*
 * Host processor model: drives the sleep request pin, counts awake rises.
 * Assumes the bench sets want_i and lag_i off the rising clock edge.
 */
`timescale 1ns/1ps
module slc_host_model (
   input  wire logic       clk_i,
   input  wire logic       want_i,
   input  wire logic [3:0] lag_i,
   input  wire logic       awake_i,
   output logic            req_o,
   output int              wakes_o
);
   int   wait_n  = 0;
   int   wakes_r = 0;
   logic awake_d = 1'b1;
   logic req_r   = 1'b0;
   assign req_o   = req_r;
   assign wakes_o = wakes_r;
   // Pin follows the wish after lag_i cycles, so a slow host is possible
   always @(posedge clk_i) begin
      if (want_i != req_r && wait_n >= int'(lag_i)) begin
         req_r  <= want_i;
         wait_n <= 0;
      end else if (want_i != req_r) begin
         wait_n <= wait_n + 1;
      end
   end
   // Awake indicator rises, sampled away from the edge that launches them
   always @(negedge clk_i) begin
      awake_d <= awake_i;
      if (awake_i && !awake_d) begin
         wakes_r <= wakes_r + 1;
      end
   end
endmodule : slc_host_model

// File: sim/slc_sleep_ctrl_tb.sv
/*
 * Bench for the sleep controller: config port, every mode, timing spans.
 * Assumes short prescalers: 20 cycles per sleep unit, 4 per wake unit.
 */
`timescale 1ns/1ps
module slc_sleep_ctrl_tb;
   import slc_pkg::*;
   localparam int SU = 20;
   localparam int WU = 4;
   logic        clk   = 1'b0;
   logic        rst   = 1'b1;
   logic        act   = 1'b0;
   logic [7:0]  rate  = 8'h00;
   logic        wr    = 1'b0;
   logic [2:0]  sel   = 3'h0;
   logic [23:0] wdata = 24'h000000;
   logic        want  = 1'b0;
   logic [3:0]  lag   = 4'h0;
   logic        nsync = 1'b0;
   logic [23:0] rdata;
   logic        err, awake, sleep, pulse, sample, req;
   int          wakes;
   int          samples     = 0;
   int          failures    = 0;
   int          check_count = 0;
   int          n;

   slc_sleep_ctrl #(.SLEEP_TICK_CYC(SU), .WAKE_TICK_CYC(WU)) dut (
      .SYS_CLK_I(clk), .RESET_I(rst), .HOST_SLEEP_REQUEST_I(req), .ACTIVITY_I(act),
      .NET_SYNC_I(nsync), .RADIO_RATE_SETTING_I(rate), .CFG_WR_I(wr), .CFG_SEL_I(sel),
      .CFG_WDATA_I(wdata), .CFG_RDATA_O(rdata), .CFG_ERR_O(err), .AWAKE_O(awake),
      .SLEEP_O(sleep), .PULSE_OUTPUT_PIN_O(pulse), .SAMPLE_O(sample));
   slc_host_model host (.clk_i(clk), .want_i(want), .lag_i(lag), .awake_i(awake),
      .req_o(req), .wakes_o(wakes));

   // 20 MHz module clock
   always #25 clk = ~clk;

   // Sync sample strobes, counted away from their launching edge
   always @(negedge clk) begin
      if (sample === 1'b1) samples <= samples + 1;
   end

   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Span within two cycles, since the edge of entry is a design choice
   task automatic near(input int got, input int exp);
      chk({23'h0, got >= exp - 2 && got <= exp + 2}, 24'h000001);
   endtask : near
   // One write; the refusal flag answers in the next cycle
   task automatic wr_reg(input logic [2:0] s, input logic [23:0] d, input logic e);
      @(negedge clk);
      wr    = 1'b1;
      sel   = s;
      wdata = d;
      @(negedge clk);
      wr = 1'b0;
      chk({23'h0, err}, {23'h0, e});
   endtask : wr_reg
   task automatic rd_reg(input logic [2:0] s, input logic [23:0] e);
      @(negedge clk);
      sel = s;
      repeat (2) @(negedge clk);
      chk(rdata, e);
   endtask : rd_reg
   // Bounded wait on the sleep (w=0) or awake (w=1) output
   task automatic wait_lvl(input bit w, input logic v, input int lim);
      n = 0;
      while (((w ? awake : sleep) !== v) && n < lim) begin
         @(negedge clk);
         n++;
      end
   endtask : wait_lvl

   task automatic t_reset;
      rd_reg(SEL_MODE, 24'h000000);
      rd_reg(SEL_OPT, 24'h000002);
      rd_reg(SEL_DIV, 24'h000001);
      rd_reg(SEL_SP, 24'h00012C);
      rd_reg(SEL_ST, 24'h000D08);
      rd_reg(SEL_STATUS, 24'h000001);
      want = 1'b1;
      repeat (12) @(negedge clk);
      chk({22'h0, awake, sleep}, 24'h000002);
      want = 1'b0;
   endtask : t_reset

   task automatic t_refuse;
      logic [26:0] bad [9] = '{{SEL_OPT, 24'h000003}, {SEL_OPT, 24'h00013F}, {SEL_DIV, 24'h000000},
         {SEL_SP, 24'h15F901}, {SEL_ST, 24'h000000}, {SEL_MODE, 24'h000007},
         {SEL_MODE, 24'h000008}, {SEL_MODE, 24'h000002}, {SEL_STATUS, 24'h000000}};
      foreach (bad[i]) wr_reg(bad[i][26:24], bad[i][23:0], 1'b1);
      rd_reg(SEL_OPT, 24'h000002);
      rd_reg(SEL_MODE, 24'h000000);
      wr_reg(SEL_OPT, 24'h00013E, 1'b0);
      wr_reg(SEL_DIV, 24'h00FFFF, 1'b0);
      wr_reg(SEL_SP, 24'h15F900, 1'b0);
      rd_reg(SEL_SP, 24'h15F900);
   endtask : t_refuse

   task automatic t_pin;
      wr_reg(SEL_MODE, 24'h000001, 1'b0);
      lag  = 4'h3;
      want = 1'b1;
      wait_lvl(0, 1'b1, 20);
      chk({22'h0, awake, sleep}, 24'h000001);
      want = 1'b0;
      wait_lvl(0, 1'b0, 20);
      chk({22'h0, awake, sleep}, 24'h000002);
      wr_reg(SEL_MODE, 24'h000000, 1'b0);
   endtask : t_pin

   task automatic t_cyclic;
      wr_reg(SEL_OPT, 24'h000002, 1'b0);
      wr_reg(SEL_DIV, 24'h000001, 1'b0);
      wr_reg(SEL_SP, 24'h000002, 1'b0);
      wr_reg(SEL_ST, 24'h000003, 1'b0);
      wr_reg(SEL_MODE, 24'h000004, 1'b0);
      wait_lvl(0, 1'b1, 200);
      wait_lvl(0, 1'b0, 200);
      near(n, 2 * SU);
      @(negedge clk);
      chk({23'h0, awake}, 24'h000001);
      wait_lvl(0, 1'b1, 100);
      near(n, WU);
      wr_reg(SEL_OPT, 24'h000102, 1'b0);
      wait_lvl(0, 1'b0, 200);
      wait_lvl(0, 1'b1, 100);
      near(n, 3 * WU);
      wait_lvl(0, 1'b0, 200);
      repeat (3) @(negedge clk);
      act = 1'b1;
      @(negedge clk);
      act = 1'b0;
      wait_lvl(0, 1'b1, 100);
      near(n, 3 * WU);
      rate = 8'h01;
      wr_reg(SEL_MODE, 24'h000008, 1'b1);
      wr_reg(SEL_OPT, 24'h000002, 1'b0);
      // Zero period in async mode keeps the device awake
      wr_reg(SEL_SP, 24'h000000, 1'b0);
      repeat (2 * SU) @(negedge clk);
      chk({22'h0, awake, sleep}, 24'h000002);
      wr_reg(SEL_SP, 24'h000002, 1'b0);
      wr_reg(SEL_MODE, 24'h000000, 1'b0);
   endtask : t_cyclic

   // Divider 3: two silent checks, then one full wake
   task automatic t_divider;
      int w0;
      wr_reg(SEL_DIV, 24'h000003, 1'b0);
      wr_reg(SEL_MODE, 24'h000004, 1'b0);
      wait_lvl(0, 1'b1, 100);
      w0 = wakes;
      for (int k = 0; k < 3; k++) begin
         wait_lvl(0, 1'b0, 200);
         repeat (2) @(negedge clk);
         chk({23'h0, awake}, {23'h0, k == 2});
         wait_lvl(0, 1'b1, 100);
         if (k < 2) near(n + 2, WU);
      end
      chk(24'(wakes - w0), 24'h000001);
      wait_lvl(0, 1'b0, 200);
      @(negedge clk);
      act = 1'b1;
      @(negedge clk);
      act = 1'b0;
      wait_lvl(1, 1'b1, 3);
      chk({23'h0, awake}, 24'h000001);
      wr_reg(SEL_MODE, 24'h000000, 1'b0);
   endtask : t_divider

   task automatic t_async_pin;
      wr_reg(SEL_MODE, 24'h000005, 1'b0);
      lag  = 4'h5;
      want = 1'b1;
      wait_lvl(0, 1'b1, 100);
      chk({23'h0, sleep}, 24'h000001);
      repeat (5) @(negedge clk);
      want = 1'b0;
      wait_lvl(0, 1'b0, 12);
      chk({22'h0, awake, sleep}, 24'h000002);
      repeat (3 * SU) @(negedge clk);
      chk({22'h0, awake, sleep}, 24'h000002);
      wr_reg(SEL_MODE, 24'h000000, 1'b0);
   endtask : t_async_pin

   // Support and synchronized modes; divider is still 3 here
   task automatic t_sync;
      int p;
      int s0;
      wr_reg(SEL_MODE, 24'h000007, 1'b0);
      repeat (50) @(negedge clk);
      chk({22'h0, awake, sleep}, 24'h000002);
      wr_reg(SEL_MODE, 24'h000004, 1'b1);
      wr_reg(SEL_MODE, 24'h000000, 1'b0);
      wr_reg(SEL_SP, 24'h000001, 1'b0);
      s0 = samples;
      wr_reg(SEL_MODE, 24'h000008, 1'b0);
      wait_lvl(0, 1'b1, 100);
      chk(24'(samples - s0), 24'h000001);
      wait_lvl(0, 1'b0, 100);
      near(n, SU);
      @(negedge clk);
      chk({23'h0, awake}, 24'h000001);
      // Network strobe mid-wake restarts the wake duration
      repeat (4) @(negedge clk);
      nsync = 1'b1;
      @(negedge clk);
      nsync = 1'b0;
      wait_lvl(0, 1'b1, 100);
      near(n, 3 * WU);
      wr_reg(SEL_SP, 24'h000000, 1'b0);
      p = 0;
      repeat (60) begin
         @(negedge clk);
         p += pulse;
      end
      chk({23'h0, p > 0 && !sleep}, 24'h000001);
   endtask : t_sync

   task automatic tally_and_finish;
      if (failures == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish

   // Watchdog: the whole sequence needs well under 4000 cycles
   initial begin
      #(20000 * 50);
      failures++;
      tally_and_finish();
   end

   initial begin
      repeat (20) @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_refuse();
      t_pin();
      t_cyclic();
      t_divider();
      t_async_pin();
      t_sync();
      tally_and_finish();
   end
endmodule : slc_sleep_ctrl_tb
